// ==== rtl/gen_reg_pkg.sv ====
package gen_reg_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int reg_count = 16;
  localparam int data_width = 32;
  localparam int parity_width = 4;
  localparam int entry_width = 36;
  localparam int index_width = 4;
  localparam int latch_width = 72;
  // ****************************************
  // Fixed register numbers and reset value
  // ****************************************
  localparam logic [3:0] scan_reg_a = 4'h0;
  localparam logic [3:0] scan_reg_b = 4'h4;
  localparam logic [3:0] edit_reg_a = 4'h1;
  localparam logic [3:0] edit_reg_b = 4'h2;
  localparam logic [35:0] entry_reset = 36'h0;
  // ****************************************
  // Bus field positions
  // ****************************************
  localparam int left_low = 0;
  localparam int right_low = 36;
  // ****************************************
  // Write source kind
  // ****************************************
  typedef enum logic [1:0] {
    wr_idle = 2'b00,
    wr_normal = 2'b01,
    wr_scan0 = 2'b10,
    wr_scan4 = 2'b11
  } write_kind_type;
endpackage : gen_reg_pkg

// ==== rtl/one_of_sixteen.sv ====
`timescale 1ns/1ps
module one_of_sixteen (
  input wire logic [3:0] field,
  input wire logic gate,
  output logic [15:0] lines
);
  // ****************************************
  // Gated one-of-sixteen decode
  // ****************************************
  always_comb begin
    lines = 16'h0000;
    if (gate) begin
      lines[field] = 1'b1;
    end
  end
endmodule : one_of_sixteen

// ==== rtl/bus_or.sv ====
`timescale 1ns/1ps
module bus_or (
  input wire logic [575:0] bank,
  input wire logic [15:0] sel,
  output logic [35:0] bus
);
  // ****************************************
  // Last OR level of a read bus
  // ****************************************
  always_comb begin
    bus = 36'h0;
    for (int i = 0; i < 16; i++) begin
      if (sel[i]) begin
        bus = bus | bank[i*36 +: 36];
      end
    end
  end
endmodule : bus_or

// ==== rtl/general_register_file.sv ====
`timescale 1ns/1ps
module general_register_file (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic early_b_gate,
  input wire logic load_control,
  input wire logic [3:0] put_away_index,
  input wire logic [31:0] staging_data,
  input wire logic [3:0] staging_parity,
  input wire logic scan_mode,
  input wire logic scan_select0,
  input wire logic scan_select4,
  input wire logic [3:0] base_field,
  input wire logic [3:0] first_register_field,
  input wire logic [3:0] second_register_field,
  input wire logic gate_first,
  input wire logic gate_first_plus_one,
  input wire logic gate_base,
  input wire logic gate_second,
  input wire logic gate_edit_reg1,
  input wire logic gate_edit_reg2,
  input wire logic gate_to_latch,
  output logic [35:0] adder_left,
  output logic [35:0] adder_right,
  output logic [71:0] register_bus_latch
);
  // ****************************************
  // Storage
  // ****************************************
  logic [35:0] general_register [16];
  logic [35:0] next_general_register [16];
  logic [575:0] bank;
  gen_reg_pkg::write_kind_type kind;
  logic [35:0] write_word;
  logic [15:0] sel_first;
  logic [15:0] sel_plus;
  logic [15:0] sel_base;
  logic [15:0] sel_second;
  logic [15:0] sel_left;
  logic [15:0] sel_right;
  logic [35:0] left_read_bus;
  logic [35:0] right_read_bus;
  logic [35:0] next_adder_left;
  logic [35:0] next_adder_right;
  logic [71:0] next_latch;

  function automatic logic [3:0] plus_one(input logic [3:0] f);
    plus_one = f | 4'h1;
  endfunction : plus_one

  // ****************************************
  // Write path
  // ****************************************
  assign write_word = {staging_data, staging_parity};
  // Scan wins so a test pattern is never overwritten by a put-away
  always_comb begin
    kind = gen_reg_pkg::wr_idle;
    if (scan_mode && scan_select0) begin
      kind = gen_reg_pkg::wr_scan0;
    end else if (scan_mode && scan_select4) begin
      kind = gen_reg_pkg::wr_scan4;
    end else if (early_b_gate && load_control) begin
      kind = gen_reg_pkg::wr_normal;
    end
  end

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      next_general_register[i] = general_register[i];
    end
    unique case (kind)
      gen_reg_pkg::wr_idle: begin
      end
      gen_reg_pkg::wr_normal: begin
        next_general_register[put_away_index] = write_word;
      end
      gen_reg_pkg::wr_scan0: begin
        next_general_register[gen_reg_pkg::scan_reg_a] = write_word;
      end
      gen_reg_pkg::wr_scan4: begin
        next_general_register[gen_reg_pkg::scan_reg_b] = write_word;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < 16; i++) begin
      if (!nrst) begin
        general_register[i] <= gen_reg_pkg::entry_reset;
      end else begin
        general_register[i] <= next_general_register[i];
      end
    end
  end

  // ****************************************
  // Read selection
  // ****************************************
  one_of_sixteen dec_first (.field(first_register_field), .gate(gate_first), .lines(sel_first));
  one_of_sixteen dec_plus (.field(plus_one(first_register_field)), .gate(gate_first_plus_one),
    .lines(sel_plus));
  one_of_sixteen dec_base (.field(base_field), .gate(gate_base), .lines(sel_base));
  one_of_sixteen dec_second (.field(second_register_field), .gate(gate_second),
    .lines(sel_second));

  always_comb begin
    sel_left = sel_first | sel_base;
    sel_left[gen_reg_pkg::edit_reg_a] = sel_left[gen_reg_pkg::edit_reg_a] | gate_edit_reg1;
    sel_left[gen_reg_pkg::edit_reg_b] = sel_left[gen_reg_pkg::edit_reg_b] | gate_edit_reg2;
    sel_right = sel_second | sel_plus;
  end

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      bank[i*36 +: 36] = general_register[i];
    end
  end

  // Both buses see every bit, so one register may sit on both
  bus_or or_left (.bank(bank), .sel(sel_left), .bus(left_read_bus));
  bus_or or_right (.bank(bank), .sel(sel_right), .bus(right_read_bus));

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    next_adder_left = left_read_bus;
    next_adder_right = right_read_bus;
    next_latch = register_bus_latch;
    if (gate_to_latch) begin
      next_latch = {left_read_bus, right_read_bus};
    end
  end

  // Registered outputs add one cycle of read latency
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      adder_left <= gen_reg_pkg::entry_reset;
      adder_right <= gen_reg_pkg::entry_reset;
      register_bus_latch <= {gen_reg_pkg::entry_reset, gen_reg_pkg::entry_reset};
    end else begin
      adder_left <= next_adder_left;
      adder_right <= next_adder_right;
      register_bus_latch <= next_latch;
    end
  end

  // ****************************************
  // Checks: write side
  // ****************************************
  sequence normal_write_s;
    early_b_gate && load_control && !scan_mode;
  endsequence

  sequence partial_write_s;
    (!early_b_gate || !load_control) && !scan_mode;
  endsequence

  sequence scan_zero_s;
    scan_mode && scan_select0;
  endsequence

  sequence scan_four_s;
    scan_mode && !scan_select0 && scan_select4;
  endsequence

  // Registers three and five stand in for the untouched ones
  hold_value_a: assert property (@(posedge mclk) disable iff (!nrst)
    partial_write_s
    |=> $stable(general_register[5]))
    else $error("register changed without write");

  hold_three_a: assert property (@(posedge mclk) disable iff (!nrst)
    partial_write_s
    |=> $stable(general_register[3]))
    else $error("register three changed without full write");

  hold_other_a: assert property (@(posedge mclk) disable iff (!nrst)
    early_b_gate && load_control && !scan_mode && put_away_index != 4'h5
    |=> $stable(general_register[5]))
    else $error("write reached an unselected register");

  write_data_a: assert property (@(posedge mclk) disable iff (!nrst)
    normal_write_s
    |=> general_register[$past(put_away_index)] == $past(write_word))
    else $error("write data lost");

  parity_keep_a: assert property (@(posedge mclk) disable iff (!nrst)
    normal_write_s
    |=> general_register[$past(put_away_index)][3:0] == $past(staging_parity))
    else $error("parity altered on write");

  scan_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
    scan_zero_s
    |=> general_register[0] == $past(write_word))
    else $error("scan write to zero lost");

  scan_four_a: assert property (@(posedge mclk) disable iff (!nrst)
    scan_four_s
    |=> general_register[4] == $past(write_word))
    else $error("scan write to four lost");

  scan_only_a: assert property (@(posedge mclk) disable iff (!nrst)
    scan_zero_s
    |=> $stable(general_register[5]))
    else $error("scan write reached another register");

  // ****************************************
  // Checks: read side
  // ****************************************
  sequence left_first_s;
    gate_first && !gate_base && !gate_edit_reg1 && !gate_edit_reg2;
  endsequence

  sequence left_base_s;
    gate_base && !gate_first && !gate_edit_reg1 && !gate_edit_reg2;
  endsequence

  sequence left_idle_s;
    !gate_first && !gate_base && !gate_edit_reg1 && !gate_edit_reg2;
  endsequence

  sequence right_second_s;
    gate_second && !gate_first_plus_one;
  endsequence

  sequence right_plus_s;
    gate_first_plus_one && !gate_second && !first_register_field[0];
  endsequence

  // Outputs lag the selects by one edge, so a write in that edge must not count
  left_bus_a: assert property (@(posedge mclk) disable iff (!nrst)
    left_first_s
    |=> adder_left == $past(general_register[first_register_field]))
    else $error("left bus wrong");

  base_bus_a: assert property (@(posedge mclk) disable iff (!nrst)
    left_base_s
    |=> adder_left == $past(general_register[base_field]))
    else $error("base field register wrong");

  left_idle_a: assert property (@(posedge mclk) disable iff (!nrst)
    left_idle_s
    |=> adder_left == 36'h0)
    else $error("left bus driven without gate");

  edit_one_a: assert property (@(posedge mclk) disable iff (!nrst)
    gate_edit_reg1 && !gate_first && !gate_base && !gate_edit_reg2
    |=> adder_left == $past(general_register[1]))
    else $error("edit gate wrong");

  edit_two_a: assert property (@(posedge mclk) disable iff (!nrst)
    gate_edit_reg2 && !gate_first && !gate_base && !gate_edit_reg1
    |=> adder_left == $past(general_register[2]))
    else $error("second edit gate wrong");

  right_bus_a: assert property (@(posedge mclk) disable iff (!nrst)
    right_second_s
    |=> adder_right == $past(general_register[second_register_field]))
    else $error("right bus wrong");

  odd_pair_a: assert property (@(posedge mclk) disable iff (!nrst)
    right_plus_s
    |=> adder_right == $past(general_register[first_register_field + 4'h1]))
    else $error("odd register wrong");

  no_gate_a: assert property (@(posedge mclk) disable iff (!nrst)
    !gate_second && !gate_first_plus_one |=> adder_right == 36'h0)
    else $error("right bus driven without gate");

  same_reg_a: assert property (@(posedge mclk) disable iff (!nrst)
    gate_first && gate_second && !gate_base && !gate_first_plus_one && !gate_edit_reg1
    && !gate_edit_reg2 && first_register_field == second_register_field
    |=> adder_left == adder_right)
    else $error("one register differs on the two buses");

  // ****************************************
  // Checks: latch
  // ****************************************
  latch_map_a: assert property (@(posedge mclk) disable iff (!nrst)
    gate_to_latch |=> register_bus_latch == {adder_left, adder_right})
    else $error("latch halves wrong");

  latch_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    !gate_to_latch
    |=> $stable(register_bus_latch))
    else $error("latch changed without gate");
endmodule : general_register_file

// ==== testbench/exec_unit_model.sv ====
`timescale 1ns/1ps
module exec_unit_model (
  input wire logic mclk,
  output logic early_b_gate,
  output logic load_control,
  output logic [3:0] put_away_index,
  output logic [31:0] staging_data,
  output logic [3:0] staging_parity,
  output logic scan_mode,
  output logic scan_select0,
  output logic scan_select4,
  output logic [3:0] base_field,
  output logic [3:0] first_register_field,
  output logic [3:0] second_register_field,
  output logic [6:0] gates
);
  // ****************************************
  // Idle levels
  // ****************************************
  initial begin
    {early_b_gate, load_control, scan_mode, scan_select0, scan_select4} = 5'h00;
    {put_away_index, staging_data, staging_parity} = 40'h0;
    {base_field, first_register_field, second_register_field, gates} = 19'h0;
  end
  // ****************************************
  // Put-away: one cycle of write controls
  // ****************************************
  task automatic put(input logic [3:0] idx, input logic [31:0] d, input logic [3:0] p,
                     input logic eb, input logic lc, input logic [1:0] sc);
    @(negedge mclk);
    early_b_gate = eb;
    load_control = lc;
    put_away_index = idx;
    {staging_data, staging_parity} = {d, p};
    {scan_select4, scan_select0, scan_mode} = {sc, |sc};
    @(negedge mclk);
    {early_b_gate, load_control, scan_mode, scan_select0, scan_select4} = 5'h00;
    // Released data turned round so a stale value cannot pass
    {staging_data, staging_parity} = ~{d, p};
  endtask : put
  // ****************************************
  // Out-gating: one cycle of selects, any mix of the seven gates in g
  // ****************************************
  task automatic sel(input logic [3:0] b, input logic [3:0] f, input logic [3:0] s,
                     input logic [6:0] g);
    @(negedge mclk);
    {base_field, first_register_field, second_register_field} = {b, f, s};
    gates = g;
    @(negedge mclk);
    gates = 7'h00;
  endtask : sel
endmodule : exec_unit_model

// ==== testbench/general_register_file_tb.sv ====
`timescale 1ns/1ps
module general_register_file_tb;
  logic mclk, nrst, early_b_gate, load_control, scan_mode, scan_select0, scan_select4;
  logic [3:0] put_away_index, staging_parity, base_field, first_register_field;
  logic [3:0] second_register_field;
  logic [31:0] staging_data;
  logic [6:0] gates;
  logic [35:0] adder_left, adder_right;
  logic [71:0] register_bus_latch;
  int failures = 0;
  int checks = 0;
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  exec_unit_model u_exec_unit_model (.mclk, .early_b_gate, .load_control, .put_away_index,
    .staging_data, .staging_parity, .scan_mode, .scan_select0, .scan_select4, .base_field,
    .first_register_field, .second_register_field, .gates);
  general_register_file u_general_register_file (.mclk, .nrst, .early_b_gate, .load_control,
    .put_away_index, .staging_data, .staging_parity, .scan_mode, .scan_select0, .scan_select4,
    .base_field, .first_register_field, .second_register_field, .gate_first(gates[6]),
    .gate_first_plus_one(gates[5]), .gate_base(gates[4]), .gate_second(gates[3]),
    .gate_edit_reg1(gates[2]), .gate_edit_reg2(gates[1]), .gate_to_latch(gates[0]),
    .adder_left, .adder_right, .register_bus_latch);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [35:0] ev(input logic [3:0] i);
    return {{8{i}}, ~i};
  endfunction : ev
  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset;
    u_exec_unit_model.sel(4'h0, 4'h0, 4'h0, 7'h49);
    check("reset latch", register_bus_latch, 72'h0);
  endtask : test_reset
  task automatic test_fill;
    for (int i = 0; i < 16; i++) u_exec_unit_model.put(i[3:0], {8{i[3:0]}}, ~i[3:0],
      1'b1, 1'b1, 2'b00);
    for (int i = 0; i < 16; i++) begin
      u_exec_unit_model.sel(4'h0, i[3:0], 4'hF - i[3:0], 7'h49);
      check("left", adder_left, ev(i[3:0]));
      check("right", adder_right, ev(4'hF - i[3:0]));
      check("latch", register_bus_latch, {ev(i[3:0]), ev(4'hF - i[3:0])});
    end
    u_exec_unit_model.sel(4'h0, 4'h5, 4'h5, 7'h48);
    check("same reg", {adder_left, adder_right}, {ev(4'h5), ev(4'h5)});
  endtask : test_fill
  task automatic test_hold;
    u_exec_unit_model.put(4'h3, 32'hFFFF_FFFF, 4'hF, 1'b1, 1'b0, 2'b00);
    u_exec_unit_model.put(4'h3, 32'hFFFF_FFFF, 4'hF, 1'b0, 1'b1, 2'b00);
    u_exec_unit_model.sel(4'h0, 4'h3, 4'h0, 7'h40);
    check("partial write", adder_left, ev(4'h3));
  endtask : test_hold
  task automatic test_paths;
    u_exec_unit_model.sel(4'h6, 4'h0, 4'h0, 7'h10);
    check("base", adder_left, ev(4'h6));
    u_exec_unit_model.sel(4'h0, 4'h2, 4'h0, 7'h20);
    check("plus one", adder_right, ev(4'h3));
    u_exec_unit_model.sel(4'h0, 4'h0, 4'h0, 7'h04);
    check("edit one", adder_left, ev(4'h1));
    u_exec_unit_model.sel(4'h0, 4'h0, 4'h0, 7'h02);
    check("edit two", adder_left, ev(4'h2));
    u_exec_unit_model.sel(4'h7, 4'h7, 4'h7, 7'h00);
    check("no gate", {adder_left, adder_right}, 72'h0);
    // Last latch load was the final fill read: registers 15 and 0
    check("latch holds", register_bus_latch, {ev(4'hF), ev(4'h0)});
  endtask : test_paths
  task automatic test_scan;
    // Load controls left low: scan must write on its own
    u_exec_unit_model.put(4'h9, 32'hA5A5_A5A5, 4'h6, 1'b0, 1'b0, 2'b01);
    u_exec_unit_model.put(4'h9, 32'h5A5A_5A5A, 4'h9, 1'b0, 1'b0, 2'b10);
    u_exec_unit_model.sel(4'h0, 4'h0, 4'h4, 7'h49);
    check("scan", register_bus_latch, 72'hA5A5A5A56_5A5A5A5A9);
    u_exec_unit_model.sel(4'h0, 4'h9, 4'h0, 7'h40);
    check("scan other", adder_left, ev(4'h9));
  endtask : test_scan
  initial begin
    nrst = 1'b0;
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    test_reset();
    test_fill();
    test_hold();
    test_paths();
    test_scan();
    finish_test();
  end
  initial begin
    #200000;
    failures++;
    finish_test();
  end
endmodule : general_register_file_tb
